// >>> hw/tfs_pkg.sv
// Constants shared by the transport front end: register map, fields, reset values.
// Assumes an APB master with 32-bit data and word-aligned byte addresses.
package tfs_pkg;
    localparam int unsigned CLK_HZ = 20000000;
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_FIFO_DELAY = 8'h04;
    localparam logic [7:0] OFS_SYNC_PATTERN = 8'h08;
    localparam logic [7:0] OFS_SYNC_PERIOD = 8'h0C;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    // Control bit positions
    localparam int unsigned CTRL_SYNC_INSERT = 0;
    localparam int unsigned CTRL_AUTO_RESET = 1;
    localparam int unsigned CTRL_SCRAMBLE_OFF = 2;
    localparam int unsigned CTRL_RS_ON = 3;
    // Status bit positions
    localparam int unsigned STAT_ALARM_STICKY = 0;
    localparam int unsigned STAT_ALARM_NOW = 1;
    localparam int unsigned STAT_SYNC_LOCKED = 2;
    localparam int unsigned STAT_WR_PTR = 8;
    localparam int unsigned STAT_RD_PTR = 16;
    // Reset values
    localparam logic [3:0] CTRL_RESET = 4'h9;
    localparam logic [6:0] FIFO_DELAY_RESET = 7'h60;
    localparam logic [7:0] SYNC_PATTERN_RESET = 8'h47;
    localparam logic [7:0] SYNC_PERIOD_RESET = 8'hCC;
    // Datapath constants
    localparam int unsigned PTR_W = 7;
    localparam int unsigned FIFO_DEPTH = 128;
    localparam int unsigned SYMBOL_DIV = 4;
    localparam logic [7:0] RS_CHECK_BYTES = 8'h10;
    localparam int unsigned RS_R = 16;
    localparam logic [7:0] GF_POLY_LOW = 8'h1D;
    localparam logic [2:0] LOCK_FIRST_STATE = 3'h3;
    localparam logic [2:0] LOCK_LAST_STATE = 3'h5;
    localparam logic [14:0] PRBS_INIT = 15'h00A9;
    localparam logic [2:0] GROUP_INVERT = 3'h0;
endpackage : tfs_pkg

// >>> hw/tfs_transport_front.sv
// Transport front end: rate FIFO, sync/error-flag reinsertion, scrambler, RS(R=16) encoder.
// Assumes one clock; byte and sample strobes arrive synchronous to pclk.
`timescale 1ns/1ps
`default_nettype none
module tfs_transport_front (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic input_byte_clock,
    input wire logic [7:0] in_data,
    input wire logic in_frame_start,
    input wire logic packet_error_in,
    input wire logic sequence_start_pulse,
    input wire logic output_sample_clock,
    input wire logic [2:0] sync_state,
    output logic [7:0] out_data,
    output logic out_valid,
    output logic out_frame_start,
    output logic fifo_alarm,
    output logic sync_locked
);
    localparam int unsigned ENTRY_W = 11;

    function automatic logic [6:0] gray_next(input logic [6:0] g);
        logic [6:0] b;
        b = '0;
        b[6] = g[6];
        for (int i = 5; i >= 0; i--) begin
            b[i] = b[i+1] ^ g[i];
        end
        b = b + 7'h01;
        return b ^ (b >> 1);
    endfunction : gray_next

    function automatic logic [7:0] gf_mul(input logic [7:0] a, input logic [7:0] b);
        logic [7:0] p;
        logic [7:0] x;
        p = '0;
        x = a;
        for (int i = 0; i < 8; i++) begin
            if (b[i]) begin
                p = p ^ x;
            end
            x = x[7] ? ((x << 1) ^ tfs_pkg::GF_POLY_LOW) : (x << 1);
        end
        return p;
    endfunction : gf_mul

    localparam int unsigned RS_GEN_W = 128;

    // Coefficients g0..g15 of the monic generator, built at elaboration
    function automatic logic [RS_GEN_W-1:0] rs_generator();
        logic [7:0] g [0:16];
        logic [7:0] root;
        logic [RS_GEN_W-1:0] r;
        for (int k = 0; k <= 16; k++) begin
            g[k] = '0;
        end
        g[0] = 8'h01;
        root = 8'h01;
        for (int i = 0; i < tfs_pkg::RS_R; i++) begin
            for (int k = 16; k > 0; k--) begin
                g[k] = g[k-1] ^ gf_mul(g[k], root);
            end
            g[0] = gf_mul(g[0], root);
            root = gf_mul(root, 8'h02);
        end
        r = '0;
        for (int k = 0; k < tfs_pkg::RS_R; k++) begin
            r[k*8 +: 8] = g[k];
        end
        return r;
    endfunction : rs_generator

    localparam logic [RS_GEN_W-1:0] RS_GEN = rs_generator();

    function automatic logic [7:0] reg_index_ok(input logic [7:0] a);
        return (a == tfs_pkg::OFS_CTRL || a == tfs_pkg::OFS_FIFO_DELAY ||
                a == tfs_pkg::OFS_SYNC_PATTERN || a == tfs_pkg::OFS_SYNC_PERIOD ||
                a == tfs_pkg::OFS_STATUS) ? 8'h01 : 8'h00;
    endfunction : reg_index_ok

    // Bus handshake: setup cycle raises pready for the access phase
    logic access;
    logic [3:0] ctrl_q;
    logic [6:0] fifo_delay_value_q;
    logic [7:0] sync_pat_q;
    logic [7:0] period_q;
    logic alarm_sticky_q;
    logic [6:0] wr_ptr_q;
    logic [6:0] rd_ptr_q;
    logic ptr_equal;
    logic fifo_delay_value_touch;
    logic status_read;

    assign access = psel && penable && pready;
    assign fifo_delay_value_touch = access && (paddr == tfs_pkg::OFS_FIFO_DELAY);
    assign status_read = access && !pwrite && (paddr == tfs_pkg::OFS_STATUS);
    assign ptr_equal = (wr_ptr_q == rd_ptr_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= '0;
        end else if (clk_en) begin
            pready <= psel && !penable;
            pslverr <= psel && !penable && (reg_index_ok(paddr) == 8'h00);
            if (psel && !penable && !pwrite) begin
                unique case (paddr)
                    tfs_pkg::OFS_CTRL: prdata <= {28'h0000000, ctrl_q};
                    tfs_pkg::OFS_FIFO_DELAY: prdata <= {25'h0000000, fifo_delay_value_q};
                    tfs_pkg::OFS_SYNC_PATTERN: prdata <= {24'h000000, sync_pat_q};
                    tfs_pkg::OFS_SYNC_PERIOD: prdata <= {24'h000000, period_q};
                    tfs_pkg::OFS_STATUS: begin
                        prdata <= '0;
                        prdata[tfs_pkg::STAT_ALARM_STICKY] <= alarm_sticky_q;
                        prdata[tfs_pkg::STAT_ALARM_NOW] <= fifo_alarm;
                        prdata[tfs_pkg::STAT_SYNC_LOCKED] <= sync_locked;
                        prdata[tfs_pkg::STAT_WR_PTR +: 7] <= wr_ptr_q;
                        prdata[tfs_pkg::STAT_RD_PTR +: 7] <= rd_ptr_q;
                    end
                    default: prdata <= '0;
                endcase
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl_q <= tfs_pkg::CTRL_RESET;
            fifo_delay_value_q <= tfs_pkg::FIFO_DELAY_RESET;
            sync_pat_q <= tfs_pkg::SYNC_PATTERN_RESET;
            period_q <= tfs_pkg::SYNC_PERIOD_RESET;
        end else if (clk_en && access && pwrite) begin
            unique case (paddr)
                tfs_pkg::OFS_CTRL: ctrl_q <= pwdata[3:0];
                tfs_pkg::OFS_FIFO_DELAY: fifo_delay_value_q <= pwdata[6:0];
                tfs_pkg::OFS_SYNC_PATTERN: sync_pat_q <= pwdata[7:0];
                tfs_pkg::OFS_SYNC_PERIOD: period_q <= pwdata[7:0];
                default: ;
            endcase
        end
    end

    // Alarm latch: a new collision in the read cycle survives the clear
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alarm_sticky_q <= 1'b0;
            fifo_alarm <= 1'b0;
        end else if (clk_en) begin
            fifo_alarm <= ptr_equal;
            alarm_sticky_q <= (alarm_sticky_q && !status_read) || ptr_equal;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync_locked <= 1'b0;
        end else if (clk_en) begin
            sync_locked <= (sync_state >= tfs_pkg::LOCK_FIRST_STATE) &&
                           (sync_state <= tfs_pkg::LOCK_LAST_STATE);
        end
    end

    // Rate FIFO; the RAM is addressed by the Gray codes directly
    logic [ENTRY_W-1:0] fifo_mem [0:tfs_pkg::FIFO_DEPTH-1];
    logic [1:0] sample_div_q;
    logic sym_tick;
    logic auto_reload;
    logic [ENTRY_W-1:0] rd_entry;

    assign sym_tick = output_sample_clock && (sample_div_q == 2'(tfs_pkg::SYMBOL_DIV - 1));
    assign auto_reload = ctrl_q[tfs_pkg::CTRL_AUTO_RESET] && ptr_equal;
    assign rd_entry = fifo_mem[rd_ptr_q];

    always_ff @(posedge pclk) begin
        if (clk_en && input_byte_clock) begin
            fifo_mem[wr_ptr_q] <= {sequence_start_pulse, packet_error_in,
                                   in_frame_start, in_data};
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sample_div_q <= '0;
        end else if (clk_en && output_sample_clock) begin
            sample_div_q <= sample_div_q + 2'h1;
        end
    end

    // Only CTRL_AUTO_RESET reloads the pointers when they meet; otherwise spacing is the host's job
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            wr_ptr_q <= '0;
            rd_ptr_q <= tfs_pkg::FIFO_DELAY_RESET;
        end else if (clk_en) begin
            if (fifo_delay_value_touch) begin
                rd_ptr_q <= pwrite ? pwdata[6:0] : fifo_delay_value_q;
                wr_ptr_q <= '0;
            end else if (auto_reload) begin
                rd_ptr_q <= fifo_delay_value_q;
                wr_ptr_q <= '0;
            end else begin
                if (input_byte_clock) begin
                    wr_ptr_q <= gray_next(wr_ptr_q);
                end
                if (sym_tick) begin
                    rd_ptr_q <= gray_next(rd_ptr_q);
                end
            end
        end
    end

    // Frame position, error flag, sync reinsertion and scrambling
    logic [7:0] f_data;
    logic f_frame;
    logic f_error;
    logic f_seq;
    logic [7:0] pos_q;
    logic [7:0] cur_pos;
    logic [2:0] group_q;
    logic [2:0] cur_group;
    logic err_pending_q;
    logic [14:0] prbs_q;
    logic [14:0] prbs_run;
    logic [7:0] prbs_byte;
    logic scr_on;
    logic is_sync;
    logic is_invert;
    logic in_gap;
    logic [7:0] s1_byte;
    logic [7:0] s1_data_q;
    logic [7:0] s1_pos_q;
    logic s1_valid_q;
    logic s1_frame_q;

    assign {f_seq, f_error, f_frame, f_data} = rd_entry;
    assign cur_pos = (f_frame || f_seq) ? 8'h00 : pos_q;
    assign cur_group = f_seq ? tfs_pkg::GROUP_INVERT : group_q;
    assign scr_on = !ctrl_q[tfs_pkg::CTRL_SCRAMBLE_OFF];
    assign is_sync = (cur_pos == 8'h00);
    assign is_invert = is_sync && scr_on && (cur_group == tfs_pkg::GROUP_INVERT);
    assign in_gap = ctrl_q[tfs_pkg::CTRL_RS_ON] &&
                    (cur_pos >= (period_q - tfs_pkg::RS_CHECK_BYTES));

    // Eight serial steps per byte, first bit onto the MSB
    always_comb begin
        logic fb;
        fb = 1'b0;
        prbs_run = prbs_q;
        prbs_byte = '0;
        for (int i = 7; i >= 0; i--) begin
            fb = prbs_run[13] ^ prbs_run[14];
            prbs_byte[i] = fb;
            prbs_run = {prbs_run[13:0], fb};
        end
    end

    always_comb begin
        s1_byte = f_data;
        if (is_sync && ctrl_q[tfs_pkg::CTRL_SYNC_INSERT] && sync_locked) begin
            s1_byte = sync_pat_q;
        end
        if (cur_pos == 8'h01 && err_pending_q) begin
            s1_byte[7] = 1'b1;
        end
        if (is_invert) begin
            s1_byte = ~s1_byte;
        end else if (scr_on && !is_sync && !in_gap) begin
            s1_byte = s1_byte ^ prbs_byte;
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pos_q <= '0;
            group_q <= tfs_pkg::GROUP_INVERT;
            err_pending_q <= 1'b0;
        end else if (clk_en && sym_tick) begin
            pos_q <= (cur_pos >= period_q - 8'h01) ? 8'h00 : cur_pos + 8'h01;
            if (is_sync) begin
                group_q <= cur_group + 3'h1;
                err_pending_q <= f_error;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prbs_q <= tfs_pkg::PRBS_INIT;
        end else if (clk_en && sym_tick) begin
            if (is_invert) begin
                prbs_q <= tfs_pkg::PRBS_INIT;
            end else if (!in_gap) begin
                prbs_q <= prbs_run;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            s1_data_q <= '0;
            s1_pos_q <= '0;
            s1_valid_q <= 1'b0;
            s1_frame_q <= 1'b0;
        end else if (clk_en) begin
            s1_valid_q <= sym_tick;
            if (sym_tick) begin
                s1_data_q <= s1_byte;
                s1_pos_q <= cur_pos;
                s1_frame_q <= is_sync;
            end
        end
    end

    // Systematic encoder: message bytes pass, the last sixteen slots carry parity
    logic [7:0] par_q [0:tfs_pkg::RS_R-1];
    logic [7:0] par_d [0:tfs_pkg::RS_R-1];
    logic [7:0] rs_fb;
    logic s1_gap;
    logic rs_on;

    assign rs_on = ctrl_q[tfs_pkg::CTRL_RS_ON];
    assign s1_gap = rs_on && (s1_pos_q >= (period_q - tfs_pkg::RS_CHECK_BYTES));
    // A fresh frame starts from clear parity, so a resync never mixes words
    assign rs_fb = s1_data_q ^ ((s1_pos_q == 8'h00) ? 8'h00 : par_q[tfs_pkg::RS_R-1]);

    generate
        for (genvar j = 0; j < tfs_pkg::RS_R; j++) begin : g_par
            logic [7:0] prev;
            if (j == 0) begin : g_first
                assign prev = 8'h00;
            end else begin : g_rest
                assign prev = (s1_pos_q == 8'h00) ? 8'h00 : par_q[j-1];
            end
            // Gap slots shift parity out; message slots divide by the generator
            assign par_d[j] = s1_gap ? prev : (prev ^ gf_mul(rs_fb, RS_GEN[j*8 +: 8]));
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    par_q[j] <= '0;
                end else if (clk_en && s1_valid_q && rs_on) begin
                    par_q[j] <= par_d[j];
                end
            end
        end
    endgenerate

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            out_data <= '0;
            out_valid <= 1'b0;
            out_frame_start <= 1'b0;
        end else if (clk_en) begin
            out_valid <= s1_valid_q;
            if (s1_valid_q) begin
                out_frame_start <= s1_frame_q;
                if (s1_gap) begin
                    out_data <= par_q[tfs_pkg::RS_R-1];
                end else begin
                    out_data <= s1_data_q;
                end
            end
        end
    end
endmodule : tfs_transport_front
`default_nettype wire

// >>> tb/tfs_front_assertions.sv
// Checker for the transport front end: APB handshake, symbol timing, lock and alarm.
// Assumes it is bound into tfs_transport_front and sees only its ports.
`timescale 1ns/1ps
`default_nettype none
module tfs_front_checker (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic clk_en,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic input_byte_clock,
    input wire logic output_sample_clock,
    input wire logic [2:0] sync_state,
    input wire logic out_valid,
    input wire logic fifo_alarm,
    input wire logic sync_locked
);
    logic [1:0] strobe_cnt_q;
    logic tick;
    logic mapped;
    logic locked_now;
    logic quiet;
    assign tick = output_sample_clock && clk_en && strobe_cnt_q == 2'h3;
    assign mapped = paddr inside {tfs_pkg::OFS_CTRL, tfs_pkg::OFS_FIFO_DELAY,
        tfs_pkg::OFS_SYNC_PATTERN, tfs_pkg::OFS_SYNC_PERIOD, tfs_pkg::OFS_STATUS};
    assign locked_now = sync_state >= tfs_pkg::LOCK_FIRST_STATE
        && sync_state <= tfs_pkg::LOCK_LAST_STATE;
    assign quiet = clk_en && !input_byte_clock && !output_sample_clock;
    // Own strobe count, so a wrong divider in the design shows up
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            strobe_cnt_q <= 2'h0;
        end else if (output_sample_clock && clk_en) begin
            strobe_cnt_q <= strobe_cnt_q + 2'h1;
        end
    end
    default clocking cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);
    sequence s_delay_write;
        psel && penable && pready && pwrite && quiet && paddr == tfs_pkg::OFS_FIFO_DELAY;
    endsequence
    sequence s_settle;
        quiet [*2];
    endsequence
    a_tick_gives_byte: assert property (tick |-> ##2 out_valid)
        else $error("symbol tick without byte");
    a_byte_needs_tick: assert property ((clk_en && !tick) ##1 clk_en |-> ##1 !out_valid)
        else $error("byte without symbol tick");
    a_valid_one_cycle: assert property (out_valid && clk_en |=> !out_valid)
        else $error("valid longer than one cycle");
    a_lock_follows_state: assert property (clk_en |=> sync_locked == $past(locked_now))
        else $error("lock flag wrong");
    a_setup_gets_ready: assert property (psel && !penable && clk_en |=> pready)
        else $error("no ready in access cycle");
    a_ready_one_cycle: assert property (pready && clk_en |=> !pready)
        else $error("ready held too long");
    a_error_on_unmapped: assert property (pready |-> pslverr == !mapped)
        else $error("error response wrong");
    a_unmapped_reads_zero: assert property (pready && pslverr && !pwrite |-> prdata == 32'h0)
        else $error("refused read not zero");
    a_delay_sets_alarm: assert property (s_delay_write ##1 s_settle |->
        fifo_alarm == ($past(pwdata[6:0], 2) == 7'h00))
        else $error("alarm wrong after delay load");
endmodule : tfs_front_checker
bind tfs_transport_front tfs_front_checker tfs_front_checker_inst (.pclk, .presetn, .clk_en,
    .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .input_byte_clock,
    .output_sample_clock, .sync_state, .out_valid, .fifo_alarm, .sync_locked);
`default_nettype wire

// >>> tb/tfs_ts_source.sv
// Transport stream source: hands bytes over as one-cycle byte strobes.
// Assumes the bench calls send_byte; idle data shows the inverse of the last byte.
`timescale 1ns/1ps
`default_nettype none
module tfs_ts_source (
    input wire logic pclk,
    output logic input_byte_clock,
    output logic [7:0] in_data,
    output logic in_frame_start,
    output logic packet_error_in,
    output logic sequence_start_pulse
);
    initial begin
        input_byte_clock = 1'b0;
        in_data = 8'hFF;
        in_frame_start = 1'b0;
        packet_error_in = 1'b0;
        sequence_start_pulse = 1'b0;
    end
    task automatic send_byte(input logic [7:0] d, input logic fs, input logic err,
        input logic ss, input int gap);
        @(posedge pclk);
        input_byte_clock <= 1'b1;
        in_data <= d;
        in_frame_start <= fs;
        packet_error_in <= err;
        sequence_start_pulse <= ss;
        @(posedge pclk);
        input_byte_clock <= 1'b0;
        // Byte and error flag go inverted; frame and sequence flags are cleared
        in_data <= ~d;
        packet_error_in <= ~err;
        in_frame_start <= 1'b0;
        sequence_start_pulse <= 1'b0;
        repeat (gap) @(posedge pclk);
    endtask : send_byte
endmodule : tfs_ts_source
`default_nettype wire

// >>> tb/test_tfs_transport_front.sv
// Self-checking bench for the transport front end over APB and the byte stream.
// Assumes the source model and the checker are compiled ahead of it.
`timescale 1ns/1ps
`default_nettype none
module test_tfs_transport_front;
    logic pclk, presetn, clk_en, psel, penable, pwrite, pready, pslverr, e;
    logic input_byte_clock, in_frame_start, packet_error_in, sequence_start_pulse;
    logic output_sample_clock, out_valid, out_frame_start, fifo_alarm, sync_locked;
    logic [7:0] paddr, in_data, out_data, b;
    logic [31:0] pwdata, prdata, r;
    logic [2:0] sync_state;
    logic [14:0] ps;
    logic [7:0] got[$];
    logic [7:0] exp_q[$];
    int n_fail = 0;
    int num_checks = 0;
    int n_fs = 0;
    int fs0;
    tfs_transport_front tfs_transport_front_inst (.pclk, .presetn, .clk_en, .psel, .penable,
        .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .input_byte_clock, .in_data,
        .in_frame_start, .packet_error_in, .sequence_start_pulse, .output_sample_clock,
        .sync_state, .out_data, .out_valid, .out_frame_start, .fifo_alarm, .sync_locked);
    tfs_ts_source tfs_ts_source_inst (.pclk, .input_byte_clock, .in_data, .in_frame_start,
        .packet_error_in, .sequence_start_pulse);
    initial begin
        pclk = 1'b0;
        forever #25 pclk = ~pclk;
    end
    always @(posedge pclk) begin
        if (out_valid === 1'b1) begin
            got.push_back(out_data);
            n_fs += int'(out_frame_start);
        end
    end
    task automatic close_out();
        $display("comparisons %0d, mismatches %0d", num_checks, n_fail);
        if (n_fail == 0 && num_checks > 0) begin
            $display("ALL CHECKS OK");
        end else begin
            $display("CHECKS NOT OK");
        end
        $finish;
    endtask : close_out
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        num_checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask : chk
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do begin
            @(posedge pclk);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k >= 16) begin
            n_fail++;
            close_out();
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb
    task automatic rd(input logic [7:0] a, input logic [31:0] exp);
        apb(1'b0, a, 32'h0);
        chk(r, exp);
    endtask : rd
    // Always whole groups of four strobes, keeping the tick phase aligned
    task automatic tick_out(input int n);
        repeat (4 * n) begin
            @(posedge pclk);
            output_sample_clock <= 1'b1;
            @(posedge pclk);
            output_sample_clock <= 1'b0;
        end
        repeat (4) @(posedge pclk);
    endtask : tick_out
    task automatic drain(input int n);
        tick_out(n);
        chk(got.size(), exp_q.size());
        foreach (exp_q[i]) chk(got[i], exp_q[i]);
        got.delete();
        exp_q.delete();
    endtask : drain
    task automatic pkt(input logic [31:0] w, input logic err, input logic ss);
        for (int i = 3; i >= 0; i--) begin
            tfs_ts_source_inst.send_byte(w[8*i+:8], i == 3, err && i == 3, ss && i == 3, 0);
        end
    endtask : pkt
    initial begin
        repeat (60000) @(posedge pclk);
        n_fail++;
        close_out();
    end
    initial begin
        presetn = 1'b0;
        clk_en = 1'b1;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        output_sample_clock = 1'b0;
        sync_state = 3'h0;
        repeat (3) @(posedge pclk);
        presetn <= 1'b1;
        rd(tfs_pkg::OFS_CTRL, 32'h9);
        rd(tfs_pkg::OFS_SYNC_PATTERN, 32'h47);
        rd(tfs_pkg::OFS_SYNC_PERIOD, 32'hCC);
        rd(tfs_pkg::OFS_FIFO_DELAY, 32'h60);
        rd(tfs_pkg::OFS_STATUS, 32'h600000);
        apb(1'b0, 8'h14, 32'h0);
        chk({r[31:1], e}, 32'h1);
        $display("test reset values done");
        // Fill every slot so no read meets an unwritten entry; wr wraps to 0
        repeat (tfs_pkg::FIFO_DEPTH) tfs_ts_source_inst.send_byte(8'h00, 1'b0, 1'b0, 1'b0, 0);
        @(posedge pclk);
        clk_en <= 1'b0;
        tfs_ts_source_inst.send_byte(8'hFF, 1'b0, 1'b0, 1'b0, 0);
        clk_en <= 1'b1;
        for (int k = 1; k <= 6; k++) begin
            tfs_ts_source_inst.send_byte(8'(k), 1'b0, 1'b0, 1'b0, k % 2);
            apb(1'b0, tfs_pkg::OFS_STATUS, 32'h0);
            chk(r[14:8], 7'(k ^ (k >> 1)));
        end
        // Fill zeros out: inverted sync, then the first two PRBS bytes
        exp_q = '{8'hFF, 8'h03, 8'hF6};
        drain(3);
        // Read side starts at Gray index 64, so Gray of 67 and of 6
        apb(1'b0, tfs_pkg::OFS_STATUS, 32'h0);
        chk(r[22:8], {7'h62, 1'b0, 7'h05});
        rd(tfs_pkg::OFS_FIFO_DELAY, 32'h60);
        apb(1'b0, tfs_pkg::OFS_STATUS, 32'h0);
        chk(r[22:8], {7'h60, 1'b0, 7'h00});
        $display("test pointer counting done");
        apb(1'b1, tfs_pkg::OFS_FIFO_DELAY, 32'h41);
        rd(tfs_pkg::OFS_FIFO_DELAY, 32'h41);
        apb(1'b0, tfs_pkg::OFS_STATUS, 32'h0);
        chk(r[22:8], {7'h41, 1'b0, 7'h00});
        apb(1'b1, tfs_pkg::OFS_FIFO_DELAY, 32'h0);
        apb(1'b0, tfs_pkg::OFS_STATUS, 32'h0);
        chk(r[1:0], 2'h3);
        apb(1'b1, tfs_pkg::OFS_FIFO_DELAY, 32'h60);
        apb(1'b0, tfs_pkg::OFS_STATUS, 32'h0);
        chk(r[1:0], 2'h1);
        apb(1'b0, tfs_pkg::OFS_STATUS, 32'h0);
        chk(r[1:0], 2'h0);
        apb(1'b1, tfs_pkg::OFS_CTRL, 32'h6);
        apb(1'b1, tfs_pkg::OFS_FIFO_DELAY, 32'h3);
        repeat (2) tfs_ts_source_inst.send_byte(8'h00, 1'b0, 1'b0, 1'b0, 1);
        repeat (3) @(posedge pclk);
        apb(1'b0, tfs_pkg::OFS_STATUS, 32'h0);
        chk({r[22:8], r[0]}, {7'h03, 1'b0, 7'h00, 1'b1});
        $display("test delay and alarm done");
        apb(1'b1, tfs_pkg::OFS_CTRL, 32'h4);
        apb(1'b1, tfs_pkg::OFS_FIFO_DELAY, 32'h0);
        pkt(32'h47123456, 1'b1, 1'b0);
        pkt(32'h4712A55A, 1'b0, 1'b0);
        exp_q = '{8'h47, 8'h92, 8'h34, 8'h56, 8'h47, 8'h12, 8'hA5, 8'h5A};
        drain(8);
        $display("test error flag done");
        apb(1'b1, tfs_pkg::OFS_CTRL, 32'h5);
        apb(1'b1, tfs_pkg::OFS_SYNC_PATTERN, 32'h5A);
        for (int s = 0; s < 6; s++) begin
            sync_state <= 3'(s);
            apb(1'b1, tfs_pkg::OFS_FIFO_DELAY, 32'h0);
            pkt(32'h00112233, 1'b0, 1'b0);
            exp_q = '{(s >= 3) ? 8'h5A : 8'h00, 8'h11, 8'h22, 8'h33};
            drain(4);
        end
        $display("test sync insertion done");
        sync_state <= 3'h0;
        apb(1'b1, tfs_pkg::OFS_CTRL, 32'h0);
        apb(1'b1, tfs_pkg::OFS_FIFO_DELAY, 32'h0);
        pkt(32'h47000000, 1'b0, 1'b1);
        pkt(32'h47000000, 1'b0, 1'b0);
        // Stage 1 at bit 0; stage 14 xor 15 feeds back and goes out
        ps = 15'h00A9;
        exp_q.push_back(8'hB8);
        for (int i = 0; i < 7; i++) begin
            for (int j = 7; j >= 0; j--) begin
                b[j] = ps[13] ^ ps[14];
                ps = {ps[13:0], b[j]};
            end
            exp_q.push_back((i == 3) ? 8'h47 : b);
        end
        drain(8);
        $display("test scrambler done");
        apb(1'b1, tfs_pkg::OFS_CTRL, 32'hC);
        apb(1'b1, tfs_pkg::OFS_SYNC_PERIOD, 32'h14);
        apb(1'b1, tfs_pkg::OFS_FIFO_DELAY, 32'h0);
        pkt(32'h47A5015A, 1'b0, 1'b0);
        // Bytes sent into the sixteen parity slots are dropped
        repeat (16) tfs_ts_source_inst.send_byte(8'hFF, 1'b0, 1'b0, 1'b0, 0);
        fs0 = n_fs;
        tick_out(20);
        chk(got.size(), 20);
        chk(n_fs - fs0, 1);
        chk({got[0], got[1], got[2], got[3]}, 32'h47A5015A);
        // Each root alpha^p of the generator must null the code word
        for (int p = 0; p < 16; p++) begin
            b = 8'h00;
            foreach (got[i]) begin
                repeat (p) b = b[7] ? ((b << 1) ^ tfs_pkg::GF_POLY_LOW) : (b << 1);
                b = b ^ got[i];
            end
            chk(b, 8'h00);
        end
        got.delete();
        $display("test check bytes done");
        close_out();
    end
endmodule : test_tfs_transport_front
`default_nettype wire
